// file: hw/bzd_pkg.sv
package bzd_pkg;
   // Register addresses in special-function space
   localparam logic [7:0] BZD_ADDR_DIVIDER = 8'h8F;
   localparam logic [7:0] BZD_ADDR_CONTROL = 8'h9F;
   // Reset values
   localparam logic [7:0] BZD_DIVIDER_RST = 8'hFF;
   localparam logic [2:0] BZD_CONTROL_RST = 3'h0;
   // Control field positions
   localparam int BZD_EN_BIT = 0;
   localparam int BZD_SEL_LSB = 1;
   localparam int BZD_SEL_MSB = 2;
   // Prescaler: 8-bit free counter, taps for /32 /64 /128 /256
   localparam int BZD_PRE_W = 8;
   localparam int BZD_TAP_BASE = 4;
   // Read data for reserved bits and unmapped addresses
   localparam logic [7:0] BZD_RD_ZERO = 8'h00;
endpackage

// file: hw/bzd_prescaler.sv
// Free-running prescaler; one-cycle tick at the chosen tap
module bzd_prescaler
(
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   input wire logic i_ce,
   input wire logic [1:0] i_sel,
   output logic o_tick
);
   typedef struct packed
   {
      logic [bzd_pkg::BZD_PRE_W-1:0] cnt;
   } bzd_pre_state_t;

   bzd_pre_state_t state_reg;
   bzd_pre_state_t state_next;
   logic [bzd_pkg::BZD_PRE_W-1:0] cnt_inc;
   logic [bzd_pkg::BZD_PRE_W-1:0] tap_mask;

   // Tap of 2^(5+sel) means all low bits below it wrap together
   always_comb
   begin
      cnt_inc = state_reg.cnt + 8'h01;
      tap_mask = 8'hFF >> (2'h3 - i_sel);
      state_next = state_reg;
      state_next.cnt = cnt_inc;
      o_tick = ((state_reg.cnt & tap_mask) == tap_mask) && i_ce;
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (!i_nrst)
         state_reg <= '0;
      else if (i_ce)
         state_reg <= state_next;
   end
endmodule

// file: hw/bzd_tone_counter.sv
// 8-bit reload counter toggling the tone on match
module bzd_tone_counter
(
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   input wire logic i_ce,
   input wire logic i_en,
   input wire logic i_tick,
   input wire logic [7:0] i_divider,
   output logic o_match
);
   typedef struct packed
   {
      logic [7:0] cnt;
   } bzd_cnt_state_t;

   bzd_cnt_state_t state_reg;
   bzd_cnt_state_t state_next;

   // Held at zero while disabled, reload on match
   always_comb
   begin
      state_next = state_reg;
      o_match = i_en && i_tick && (state_reg.cnt == i_divider);
      if (!i_en)
         state_next.cnt = 8'h00;
      else if (o_match)
         state_next.cnt = 8'h00;
      else if (i_tick)
         state_next.cnt = state_reg.cnt + 8'h01;
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (!i_nrst)
         state_reg <= '0;
      else if (i_ce)
         state_reg <= state_next;
   end
endmodule

// file: hw/bzd_top.sv
// Functional notes
// - Tone made by 8-bit counter on prescaler tap, compared with divider
// - Square wave driven on dedicated tone output pin
// - Frequency is clock over two times prescale times divider plus one
// - Control bits two and one choose the prescaler tap
// - Divider zero fastest tap gives 250 kHz at 16 MHz
// - Divider is 8-bit read/write, resets to all ones
// - Divider at 8F, control at 9F, control resets to zero
// - Select codes 0..3 pick clock over 32, 64, 128, 256
// - Control bit zero enables tone output
module bzd_top
(
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   input wire logic i_ce,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   output logic o_tone_output_pin
);
   typedef struct packed
   {
      logic [7:0] tone_divider;
      logic [1:0] tone_clock_select;
      logic tone_output_enable;
      logic tone;
      logic [7:0] rdata;
   } bzd_state_t;

   bzd_state_t state_reg;
   bzd_state_t state_next;
   logic tick;
   logic match;

   // Prescaler follows the live select; a change may shorten one period
   bzd_prescaler u_pre
   (
      .i_sys_clk(i_sys_clk),
      .i_nrst(i_nrst),
      .i_ce(i_ce),
      .i_sel(state_reg.tone_clock_select),
      .o_tick(tick)
   );

   bzd_tone_counter u_cnt
   (
      .i_sys_clk(i_sys_clk),
      .i_nrst(i_nrst),
      .i_ce(i_ce),
      .i_en(state_reg.tone_output_enable),
      .i_tick(tick),
      .i_divider(state_reg.tone_divider),
      .o_match(match)
   );

   // Register writes, read data and tone toggle
   always_comb
   begin
      state_next = state_reg;
      state_next.rdata = bzd_pkg::BZD_RD_ZERO;
      if (i_wr)
      begin
         if (i_addr == bzd_pkg::BZD_ADDR_DIVIDER)
            state_next.tone_divider = i_wdata;
         else if (i_addr == bzd_pkg::BZD_ADDR_CONTROL)
         begin
            state_next.tone_clock_select = i_wdata[bzd_pkg::BZD_SEL_MSB:bzd_pkg::BZD_SEL_LSB];
            state_next.tone_output_enable = i_wdata[bzd_pkg::BZD_EN_BIT];
         end
      end
      if (i_rd)
      begin
         if (i_addr == bzd_pkg::BZD_ADDR_DIVIDER)
            state_next.rdata = state_reg.tone_divider;
         else if (i_addr == bzd_pkg::BZD_ADDR_CONTROL)
            state_next.rdata = {5'h00, state_reg.tone_clock_select, state_reg.tone_output_enable};
      end
      // Half period is prescale times (divider+1), so full is twice that
      if (!state_reg.tone_output_enable)
         state_next.tone = 1'b0;
      else if (match)
         state_next.tone = ~state_reg.tone;
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (!i_nrst)
      begin
         state_reg.tone_divider <= bzd_pkg::BZD_DIVIDER_RST;
         state_reg.tone_clock_select <= bzd_pkg::BZD_CONTROL_RST[2:1];
         state_reg.tone_output_enable <= bzd_pkg::BZD_CONTROL_RST[0];
         state_reg.tone <= 1'b0;
         state_reg.rdata <= bzd_pkg::BZD_RD_ZERO;
      end
      else if (i_ce)
         state_reg <= state_next;
   end

   assign o_rdata = state_reg.rdata;
   assign o_tone_output_pin = state_reg.tone;

   // Pin parked low while the enable is clear
   a_disabled_low: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      i_ce && !state_reg.tone_output_enable |=> !o_tone_output_pin)
      else $error("tone high while disabled");

   // Every match flips the pin exactly once
   a_toggle_on_match: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      i_ce && match |=> o_tone_output_pin != $past(o_tone_output_pin))
      else $error("no toggle on match");

   // Without a match the pin must not move, else the duty drifts
   a_hold_no_match: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      i_ce && !match && state_reg.tone_output_enable |=> $stable(o_tone_output_pin))
      else $error("tone changed without match");

   // Divider write lands in the cycle after the strobe
   a_div_write: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      i_ce && i_wr && i_addr == bzd_pkg::BZD_ADDR_DIVIDER |=> state_reg.tone_divider == $past(i_wdata))
      else $error("divider write lost");

   // Control read shows select and enable, reserved bits zero
   a_ctl_read: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      i_ce && i_rd && i_addr == bzd_pkg::BZD_ADDR_CONTROL
      |=> o_rdata == {5'h00, $past(state_reg.tone_clock_select), $past(state_reg.tone_output_enable)})
      else $error("control read wrong");

   // Enable bit follows the written value
   a_ctl_write: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      i_ce && i_wr && i_addr == bzd_pkg::BZD_ADDR_CONTROL
      |=> state_reg.tone_output_enable == $past(i_wdata[bzd_pkg::BZD_EN_BIT]))
      else $error("enable write lost");

   // Fastest setting: the next match comes exactly one tap period later
   a_fast_period: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      i_ce && match && state_reg.tone_divider == 8'h00 && state_reg.tone_clock_select == 2'h0
      && state_reg.tone_output_enable
      |-> ##32 (match || !i_ce || !state_reg.tone_output_enable || state_reg.tone_clock_select != 2'h0
      || state_reg.tone_divider != 8'h00))
      else $error("fast period");

   // No tick eight clocks after a tap 0 tick
   a_tick_spacing: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      i_ce && tick && state_reg.tone_clock_select == 2'h0 ##1 (i_ce && state_reg.tone_clock_select == 2'h0)[*8]
      |-> !tick)
      else $error("tick spacing too short");

   // Unmapped addresses read as zero
   a_unmapped_zero: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      i_ce && i_rd && i_addr != bzd_pkg::BZD_ADDR_DIVIDER && i_addr != bzd_pkg::BZD_ADDR_CONTROL
      |=> o_rdata == bzd_pkg::BZD_RD_ZERO)
      else $error("unmapped read not zero");

   // Divider leaves reset at all ones
   a_reset_divider: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      $rose(i_nrst) |-> state_reg.tone_divider == bzd_pkg::BZD_DIVIDER_RST)
      else $error("divider reset value wrong");

   // Control leaves reset cleared, so the tone starts off
   a_reset_control: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      $rose(i_nrst) |-> state_reg.tone_clock_select == 2'h0 && !state_reg.tone_output_enable)
      else $error("control reset value wrong");

   // Outputs quiet straight after reset
   a_reset_outputs: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      $rose(i_nrst) |-> o_rdata == bzd_pkg::BZD_RD_ZERO && !o_tone_output_pin)
      else $error("outputs not quiet after reset");

   // Read data stands one cycle only, then back to zero
   a_rdata_one_cycle: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      i_ce && !i_rd |=> o_rdata == bzd_pkg::BZD_RD_ZERO)
      else $error("read data lingered");

   // Divider read returns the held value
   a_div_read: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      i_ce && i_rd && i_addr == bzd_pkg::BZD_ADDR_DIVIDER |=> o_rdata == $past(state_reg.tone_divider))
      else $error("divider read wrong");

   // Back-to-back write then read sees the new divider
   a_div_rd_after_wr: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      i_ce && i_wr && i_addr == bzd_pkg::BZD_ADDR_DIVIDER
      ##1 i_ce && i_rd && i_addr == bzd_pkg::BZD_ADDR_DIVIDER
      |=> o_rdata == $past(i_wdata, 2))
      else $error("divider read after write wrong");

   // Reserved control bits always read zero
   a_rdata_rsvd: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      i_ce && i_rd && i_addr == bzd_pkg::BZD_ADDR_CONTROL |=> o_rdata[7:3] == 5'h00)
      else $error("reserved control bits set");

   // Select field follows the written bits two and one
   a_sel_write: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      i_ce && i_wr && i_addr == bzd_pkg::BZD_ADDR_CONTROL
      |=> state_reg.tone_clock_select == $past(i_wdata[bzd_pkg::BZD_SEL_MSB:bzd_pkg::BZD_SEL_LSB]))
      else $error("select write lost");

   // Divider only changes on its own write
   a_no_wr_div: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      i_ce && !(i_wr && i_addr == bzd_pkg::BZD_ADDR_DIVIDER) |=> $stable(state_reg.tone_divider))
      else $error("divider changed without write");

   // Control only changes on its own write
   a_no_wr_ctl: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      i_ce && !(i_wr && i_addr == bzd_pkg::BZD_ADDR_CONTROL)
      |=> $stable(state_reg.tone_clock_select) && $stable(state_reg.tone_output_enable))
      else $error("control changed without write");

   // Writes to other addresses touch nothing here
   a_unmapped_write: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      i_ce && i_wr && i_addr != bzd_pkg::BZD_ADDR_DIVIDER && i_addr != bzd_pkg::BZD_ADDR_CONTROL
      |=> $stable(state_reg.tone_divider) && $stable(state_reg.tone_clock_select)
      && $stable(state_reg.tone_output_enable))
      else $error("unmapped write changed state");

   // Clock enable low freezes all state, strobes included
   a_ce_freeze_state: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      !i_ce |=> state_reg == $past(state_reg))
      else $error("state moved while frozen");

   // Frozen pin keeps its level
   a_ce_freeze_pin: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      !i_ce |=> $stable(o_tone_output_pin))
      else $error("pin moved while frozen");

   // No tick while frozen, else the counter would skip
   a_tick_needs_ce: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      !i_ce |-> !tick)
      else $error("tick while frozen");

   // Tap 0 ticks every 32 clocks
   a_tick_sel0: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      i_ce && tick && state_reg.tone_clock_select == 2'h0
      |-> ##32 (tick || !i_ce || state_reg.tone_clock_select != 2'h0))
      else $error("tap 0 period wrong");

   // Tap 1 ticks every 64 clocks
   a_tick_sel1: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      i_ce && tick && state_reg.tone_clock_select == 2'h1
      |-> ##64 (tick || !i_ce || state_reg.tone_clock_select != 2'h1))
      else $error("tap 1 period wrong");

   // Tap 3 ticks every 256 clocks
   a_tick_sel3: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      i_ce && tick && state_reg.tone_clock_select == 2'h3
      |-> ##256 (tick || !i_ce || state_reg.tone_clock_select != 2'h3))
      else $error("tap 3 period wrong");

   // A match needs a tick and the enable
   a_match_needs_tick: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      match |-> tick && state_reg.tone_output_enable)
      else $error("match without tick");

   // Disabled driver never matches
   a_match_disabled: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      !state_reg.tone_output_enable |-> !match)
      else $error("match while disabled");

   // Fastest setting cannot match twice in a row
   a_fast_no_early: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      i_ce && match && state_reg.tone_divider == 8'h00 && state_reg.tone_clock_select == 2'h0
      |=> !match)
      else $error("fast match too early");

   // Clearing the enable parks the pin two cycles after the write strobe
   a_clear_parks_low: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      i_ce && i_wr && i_addr == bzd_pkg::BZD_ADDR_CONTROL && !i_wdata[bzd_pkg::BZD_EN_BIT]
      ##1 i_ce |=> !o_tone_output_pin)
      else $error("pin not parked after clear");

   // Counter held at zero while the driver is off
   a_counter_zero_off: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      i_ce && !state_reg.tone_output_enable |=> u_cnt.state_reg.cnt == 8'h00)
      else $error("counter not held at zero");

   // Counter reloads to zero on every match
   a_counter_reload: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      i_ce && match |=> u_cnt.state_reg.cnt == 8'h00)
      else $error("counter not reloaded");

   // Counter steps by one per tick between matches
   a_counter_count: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      i_ce && tick && !match && state_reg.tone_output_enable
      |=> u_cnt.state_reg.cnt == $past(u_cnt.state_reg.cnt) + 8'h01)
      else $error("counter step wrong");

   // Counter idle between ticks
   a_counter_idle: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
      i_ce && !tick && state_reg.tone_output_enable |=> $stable(u_cnt.state_reg.cnt))
      else $error("counter moved without tick");

   // Main scenarios
   c_enable: cover property (@(posedge i_sys_clk) disable iff (!i_nrst) i_wr && i_addr == bzd_pkg::BZD_ADDR_CONTROL);
   c_toggle: cover property (@(posedge i_sys_clk) disable iff (!i_nrst) $rose(o_tone_output_pin));
   c_slow_tap: cover property (@(posedge i_sys_clk) disable iff (!i_nrst) match && state_reg.tone_clock_select == 2'h3);
   c_fast_match: cover property (@(posedge i_sys_clk) disable iff (!i_nrst)
      match && state_reg.tone_divider == 8'h00 && state_reg.tone_clock_select == 2'h0);
   c_freeze: cover property (@(posedge i_sys_clk) disable iff (!i_nrst) !i_ce && state_reg.tone_output_enable);
endmodule

// file: tb/bzd_buzzer_model.sv
// Piezo load: times each half period of the tone pin in system clocks
module bzd_buzzer_model
(
   input wire logic i_sys_clk,
   input wire logic i_tone,
   output int o_half_len,
   output int o_edges
);
   timeunit 1ns;
   timeprecision 1ps;
   logic tone_prev = 1'b0;
   int run_len = 0;
   initial o_half_len = 0;
   initial o_edges = 0;
   // Length of last complete level; first one after enable may be short
   always_ff @(posedge i_sys_clk)
   begin
      tone_prev <= i_tone;
      run_len <= (i_tone !== tone_prev) ? 1 : run_len + 1;
      if (i_tone !== tone_prev)
      begin
         o_half_len <= run_len;
         o_edges <= o_edges + 1;
      end
   end
endmodule

// file: tb/tb_bzd_top.sv
module tb_bzd_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_sys_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic i_ce = 1'b1;
   logic [7:0] i_addr = 8'h00;
   logic [7:0] i_wdata = 8'h00;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [7:0] o_rdata;
   logic o_tone_output_pin;
   logic [7:0] rd;
   int half_len;
   int edges;
   int num_errors = 0;
   int samples_checked = 0;
   // 40 MHz system clock
   always #12.5 i_sys_clk = ~i_sys_clk;
   bzd_top i_bzd_top(.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_tone_output_pin(o_tone_output_pin));
   bzd_buzzer_model i_bzd_buzzer_model(.i_sys_clk(i_sys_clk), .i_tone(o_tone_output_pin), .o_half_len(half_len),
      .o_edges(edges));
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_sys_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_sys_clk);
      i_wr <= 1'b0;
   endtask
   // Read data stands only in the cycle after the strobe
   task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_sys_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_sys_clk);
      i_rd <= 1'b0;
      #1 d = o_rdata;
   endtask
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED at %0t: byte %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_len(input int got, input int exp);
      samples_checked++;
      if (got != exp)
      begin
         num_errors++;
         $display("CHECK FAILED at %0t: half period %0d expected %0d", $time, got, exp);
      end
   endtask
   task automatic close_out;
      $display("errors %0d, checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic t_reset_values;
      reg_rd(8'h8F, rd); chk_byte(rd, 8'hFF);
      reg_rd(8'h9F, rd); chk_byte(rd, 8'h00);
      reg_rd(8'h90, rd); chk_byte(rd, 8'h00);
   endtask
   // Divider write/read of 00 and A5, unmapped write, reserved control bits
   task automatic t_reg_access;
      reg_wr(8'h8F, 8'h00);
      reg_wr(8'h8E, 8'h33);
      reg_rd(8'h8F, rd); chk_byte(rd, 8'h00);
      reg_wr(8'h8F, 8'hA5);
      reg_rd(8'h8F, rd); chk_byte(rd, 8'hA5);
      reg_wr(8'h9F, 8'hFE);
      reg_rd(8'h9F, rd); chk_byte(rd, 8'h06);
      reg_wr(8'h9F, 8'h00);
   endtask
   // Every tap with two divider values; third edge gives a full half period
   task automatic t_tone_rates;
      int start;
      int k;
      for (int sel = 0; sel < 4; sel++)
         for (int dv = 0; dv < 3; dv += 2)
         begin
            reg_wr(8'h8F, dv[7:0]);
            reg_wr(8'h9F, {5'h00, sel[1:0], 1'b1});
            start = edges;
            for (k = 0; k < 4000 && edges < start + 3; k++)
               @(posedge i_sys_clk);
            #1 chk_len(half_len, (32 << sel) * (dv + 1));
            reg_wr(8'h9F, 8'h00);
         end
   endtask
   // Clearing the enable parks the pin low and keeps it there
   task automatic t_disable;
      reg_wr(8'h8F, 8'h00);
      reg_wr(8'h9F, 8'h01);
      repeat (50) @(posedge i_sys_clk);
      reg_wr(8'h9F, 8'h00);
      repeat (2) @(posedge i_sys_clk);
      #1 chk_byte({7'h00, o_tone_output_pin}, 8'h00);
      repeat (300) @(posedge i_sys_clk);
      #1 chk_byte({7'h00, o_tone_output_pin}, 8'h00);
   endtask
   // Clock enable low freezes the pin and drops strobes; read data then clears
   task automatic t_freeze;
      logic held;
      reg_wr(8'h8F, 8'h00);
      reg_wr(8'h9F, 8'h05);
      repeat (100) @(posedge i_sys_clk);
      i_ce <= 1'b0;
      @(posedge i_sys_clk);
      #1 held = o_tone_output_pin;
      reg_wr(8'h8F, 8'h77);
      repeat (300) @(posedge i_sys_clk);
      #1 chk_byte({7'h00, o_tone_output_pin}, {7'h00, held});
      @(posedge i_sys_clk);
      i_ce <= 1'b1;
      reg_rd(8'h8F, rd); chk_byte(rd, 8'h00);
      @(posedge i_sys_clk);
      #1 chk_byte(o_rdata, 8'h00);
      reg_wr(8'h9F, 8'h00);
   endtask
   // Main sequence
   initial
   begin
      repeat (20) @(posedge i_sys_clk);
      i_nrst <= 1'b1;
      t_reset_values;
      t_reg_access;
      t_tone_rates;
      t_disable;
      t_freeze;
      close_out;
   end
   // Watchdog well beyond the longest tone sweep
   initial
   begin
      repeat (60000) @(posedge i_sys_clk);
      num_errors++;
      close_out;
   end
endmodule
